/* src/uemr_regs.vh */
// Register map, field positions and encodings of the endpoint mode responder
`ifndef UEMR_REGS_VH
`define UEMR_REGS_VH
// Byte addresses on APB
`define UEMR_ADDR_MODE 12'h000
`define UEMR_ADDR_COUNT 12'h004
`define UEMR_ADDR_STATUS 12'h008
`define UEMR_ADDR_W 12
// Mode and count register fields
`define UEMR_MODE_LSB 0
`define UEMR_MODE_MSB 3
`define UEMR_STALL_BIT 7
`define UEMR_CNT_MSB 3
`define UEMR_CNT_LSB 0
// Register select bits of the bus decode
`define UEMR_SEL_MODE 0
`define UEMR_SEL_COUNT 1
`define UEMR_SEL_STATUS 2
`define UEMR_SEL_W 3
// Number of token type flags
`define UEMR_FLAG_W 3
// Status register bits: token type flags
`define UEMR_ST_SETUP 0
`define UEMR_ST_IN 1
`define UEMR_ST_OUT 2
// Mode encodings
`define UEMR_M_DISABLE 4'h0
`define UEMR_M_NAK_INOUT 4'h1
`define UEMR_M_STATUS_OUT 4'h2
`define UEMR_M_STALL_INOUT 4'h3
`define UEMR_M_IGNORE_INOUT 4'h4
`define UEMR_M_RSVD5 4'h5
`define UEMR_M_STATUS_IN 4'h6
`define UEMR_M_RSVD7 4'h7
`define UEMR_M_NAK_OUT 4'h8
`define UEMR_M_ACK_OUT 4'h9
`define UEMR_M_NAKOUT_STIN 4'hA
`define UEMR_M_ACKOUT_NAKIN 4'hB
`define UEMR_M_NAK_IN 4'hC
`define UEMR_M_ACK_IN 4'hD
`define UEMR_M_NAKIN_STOUT 4'hE
`define UEMR_M_ACKIN_STOUT 4'hF
// Token codes at the token port
`define UEMR_TOK_SETUP 2'h1
`define UEMR_TOK_IN 2'h2
`define UEMR_TOK_OUT 2'h3
// Response codes
`define UEMR_R_NONE 3'h0
`define UEMR_R_ACK 3'h1
`define UEMR_R_NAK 3'h2
`define UEMR_R_STALL 3'h3
`define UEMR_R_TXCNT 3'h4
`define UEMR_R_TX0 3'h5
`endif

/* src/uemr_responder.v */
// Endpoint mode responder: mode register, token decision and automatic mode rewrites
`timescale 1ns/1ps
`default_nettype none
`include "uemr_regs.vh"
module uemr_responder (
    input wire CLOCK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire TOKEN_VALID,
    input wire [1:0] TOKEN_TYPE,
    input wire TOKEN_OK,
    input wire [3:0] OUT_LENGTH,
    input wire OUT_TOGGLE,
    input wire HOST_ACK,
    output reg RESP_VALID,
    output reg [2:0] RESP_CODE,
    output reg [3:0] RESP_LENGTH
);

// ----------------------------------------
// State
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_WAIT_ACK = 2'b10;

reg [3:0] mode;
reg stall_bit;
reg [3:0] byte_count;
wire [`UEMR_FLAG_W-1:0] token_flags;
reg [1:0] state;
reg [3:0] pending_mode;
reg pending_rewrite;

reg [2:0] next_resp;
reg next_rewrite_now;
reg next_rewrite_on_ack;
reg [3:0] next_rewrite_mode;

// Decode of SETUP-accepting encodings, used by response and rewrite logic
function accepts_setup;
    input [3:0] m;
    begin
        case (m)
            `UEMR_M_NAK_INOUT, `UEMR_M_STATUS_OUT, `UEMR_M_STALL_INOUT, `UEMR_M_IGNORE_INOUT,
            `UEMR_M_STATUS_IN, `UEMR_M_NAKOUT_STIN, `UEMR_M_ACKOUT_NAKIN, `UEMR_M_NAKIN_STOUT,
            `UEMR_M_ACKIN_STOUT: accepts_setup = 1'b1;
            default: accepts_setup = 1'b0;
        endcase
    end
endfunction

// Status check: zero-length payload with DATA1
function status_ok;
    input [3:0] len;
    input tog;
    begin
        status_ok = (len == 4'h0) && tog;
    end
endfunction

// ----------------------------------------
// Token decision
// ----------------------------------------
always @* begin
    next_resp = `UEMR_R_NONE;
    next_rewrite_now = 1'b0;
    next_rewrite_on_ack = 1'b0;
    next_rewrite_mode = mode;
    if (TOKEN_VALID && TOKEN_OK && state == ST_IDLE) begin
        case (TOKEN_TYPE)
            `UEMR_TOK_SETUP: begin
                if (accepts_setup(mode)) begin
                    next_resp = `UEMR_R_ACK;
                    next_rewrite_now = 1'b1;
                    next_rewrite_mode = `UEMR_M_NAK_INOUT;
                end
            end
            `UEMR_TOK_IN: begin
                case (mode)
                    `UEMR_M_NAK_INOUT, `UEMR_M_ACKOUT_NAKIN, `UEMR_M_NAK_IN, `UEMR_M_NAKIN_STOUT:
                        next_resp = `UEMR_R_NAK;
                    `UEMR_M_STATUS_OUT, `UEMR_M_STALL_INOUT: next_resp = `UEMR_R_STALL;
                    `UEMR_M_STATUS_IN, `UEMR_M_NAKOUT_STIN: next_resp = `UEMR_R_TX0;
                    `UEMR_M_ACK_IN: begin
                        next_resp = stall_bit ? `UEMR_R_STALL : `UEMR_R_TXCNT;
                        next_rewrite_on_ack = ~stall_bit;
                        next_rewrite_mode = `UEMR_M_NAK_IN;
                    end
                    `UEMR_M_ACKIN_STOUT, `UEMR_M_RSVD7: begin
                        next_resp = `UEMR_R_TXCNT;
                        next_rewrite_on_ack = (mode == `UEMR_M_ACKIN_STOUT);
                        next_rewrite_mode = `UEMR_M_NAKIN_STOUT;
                    end
                    default: next_resp = `UEMR_R_NONE;
                endcase
            end
            `UEMR_TOK_OUT: begin
                case (mode)
                    `UEMR_M_NAK_INOUT, `UEMR_M_NAK_OUT, `UEMR_M_NAKOUT_STIN: next_resp = `UEMR_R_NAK;
                    `UEMR_M_STALL_INOUT, `UEMR_M_STATUS_IN: next_resp = `UEMR_R_STALL;
                    `UEMR_M_STATUS_OUT, `UEMR_M_NAKIN_STOUT, `UEMR_M_ACKIN_STOUT:
                        next_resp = status_ok(OUT_LENGTH, OUT_TOGGLE) ? `UEMR_R_ACK : `UEMR_R_STALL;
                    `UEMR_M_ACKOUT_NAKIN: begin
                        next_resp = `UEMR_R_ACK;
                        next_rewrite_now = 1'b1;
                        next_rewrite_mode = `UEMR_M_NAK_INOUT;
                    end
                    `UEMR_M_ACK_OUT: begin
                        next_resp = stall_bit ? `UEMR_R_STALL : `UEMR_R_ACK;
                        next_rewrite_now = ~stall_bit;
                        next_rewrite_mode = `UEMR_M_NAK_OUT;
                    end
                    // Reserved 0101 answers OUT only, with ACK
                    `UEMR_M_RSVD5: next_resp = `UEMR_R_ACK;
                    default: next_resp = `UEMR_R_NONE;
                endcase
            end
            default: next_resp = `UEMR_R_NONE;
        endcase
    end
end

// ----------------------------------------
// Bus decode
// ----------------------------------------
// One-hot register select, shared by write strobes, error flag and read mux
function [`UEMR_SEL_W-1:0] reg_select;
    input [`UEMR_ADDR_W-1:0] addr;
    begin
        reg_select = {`UEMR_SEL_W{1'b0}};
        case (addr)
            `UEMR_ADDR_MODE: begin
                reg_select[`UEMR_SEL_MODE] = 1'b1;
            end
            `UEMR_ADDR_COUNT: begin
                reg_select[`UEMR_SEL_COUNT] = 1'b1;
            end
            `UEMR_ADDR_STATUS: begin
                reg_select[`UEMR_SEL_STATUS] = 1'b1;
            end
            default: begin
                reg_select = {`UEMR_SEL_W{1'b0}};
            end
        endcase
    end
endfunction

wire [`UEMR_SEL_W-1:0] sel = reg_select(PADDR);
wire setup_phase = PSEL && !PENABLE;
wire bus_access = PSEL && PENABLE && PREADY;
wire addr_ok = |sel;
wire fw_write = bus_access && PWRITE;
wire fw_mode_wr = fw_write && sel[`UEMR_SEL_MODE];
wire fw_count_wr = fw_write && sel[`UEMR_SEL_COUNT];
wire flags_clear = fw_write && sel[`UEMR_SEL_STATUS];

// ----------------------------------------
// Handshake decode
// ----------------------------------------
wire ack_done = state == ST_WAIT_ACK && TOKEN_VALID == 1'b0 && HOST_ACK;
wire ack_abort = state == ST_WAIT_ACK && TOKEN_VALID;
wire tok_hit = TOKEN_VALID && TOKEN_OK && state == ST_IDLE;
wire data_answer = (next_resp == `UEMR_R_TXCNT) || (next_resp == `UEMR_R_TX0);

// ----------------------------------------
// Bus answer
// ----------------------------------------
// No wait state: decode is registered, so the answer trails setup by one clock
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
    end else begin
        PREADY <= setup_phase;
        PSLVERR <= setup_phase && !addr_ok;
    end
end

// Read data is captured in setup and held until the next read
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        PRDATA <= 32'h0;
    end else if (setup_phase && !PWRITE) begin
        if (sel[`UEMR_SEL_MODE]) begin
            PRDATA <= {24'h0, stall_bit, 3'h0, mode};
        end else if (sel[`UEMR_SEL_COUNT]) begin
            PRDATA <= {28'h0, byte_count};
        end else if (sel[`UEMR_SEL_STATUS]) begin
            PRDATA <= {29'h0, token_flags};
        end else begin
            PRDATA <= 32'h0;
        end
    end
end

// ----------------------------------------
// Mode field
// ----------------------------------------
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        mode <= `UEMR_M_DISABLE;
    end else begin
        // rewrite on the token or after handshake, wins over firmware
        if (next_rewrite_now) begin
            mode <= next_rewrite_mode;
        end else if (ack_done && pending_rewrite) begin
            mode <= pending_mode;
        end else if (fw_mode_wr) begin
            mode <= PWDATA[`UEMR_MODE_MSB:`UEMR_MODE_LSB];
        end
    end
end

// Stall bit only changes by firmware; the engine never touches it
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        stall_bit <= 1'b0;
    end else if (fw_mode_wr) begin
        stall_bit <= PWDATA[`UEMR_STALL_BIT];
    end
end

// ----------------------------------------
// Byte count
// ----------------------------------------
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        byte_count <= 4'h0;
    end else if (fw_count_wr) begin
        byte_count <= PWDATA[`UEMR_CNT_MSB:`UEMR_CNT_LSB];
    end
end

// ----------------------------------------
// Data handshake wait
// ----------------------------------------
// Only data answers wait for the host; its ACK applies the deferred rewrite
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        state <= ST_IDLE;
        pending_mode <= `UEMR_M_DISABLE;
        pending_rewrite <= 1'b0;
    end else begin
        case (state)
            ST_IDLE: begin
                if (tok_hit && data_answer) begin
                    state <= ST_WAIT_ACK;
                    pending_rewrite <= next_rewrite_on_ack;
                    pending_mode <= next_rewrite_mode;
                end
            end
            ST_WAIT_ACK: begin
                // A new token means the host gave up on the packet: no rewrite
                if (ack_done || ack_abort) begin
                    state <= ST_IDLE;
                    pending_rewrite <= 1'b0;
                end
            end
            default: begin
                state <= ST_IDLE;
                pending_rewrite <= 1'b0;
            end
        endcase
    end
end

// ----------------------------------------
// Token flags
// ----------------------------------------
wire [`UEMR_FLAG_W-1:0] flag_set;
assign flag_set[`UEMR_ST_SETUP] = tok_hit && TOKEN_TYPE == `UEMR_TOK_SETUP;
assign flag_set[`UEMR_ST_IN] = tok_hit && TOKEN_TYPE == `UEMR_TOK_IN;
assign flag_set[`UEMR_ST_OUT] = tok_hit && TOKEN_TYPE == `UEMR_TOK_OUT;

// Set wins over a same-cycle clear, so firmware never loses a token
genvar gi;
generate
    for (gi = 0; gi < `UEMR_FLAG_W; gi = gi + 1) begin : g_flag
        reg flag_q;
        always @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                flag_q <= 1'b0;
            end else if (flag_set[gi]) begin
                flag_q <= 1'b1;
            end else if (flags_clear && PWDATA[gi]) begin
                flag_q <= 1'b0;
            end
        end
        assign token_flags[gi] = flag_q;
    end
endgenerate

// ----------------------------------------
// Token answer
// ----------------------------------------
// Answer stands one cycle; length is zero unless counted data goes out
always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
        RESP_VALID <= 1'b0;
        RESP_CODE <= `UEMR_R_NONE;
        RESP_LENGTH <= 4'h0;
    end else begin
        RESP_VALID <= next_resp != `UEMR_R_NONE;
        RESP_CODE <= next_resp;
        if (next_resp == `UEMR_R_TXCNT) begin
            RESP_LENGTH <= byte_count;
        end else begin
            RESP_LENGTH <= 4'h0;
        end
    end
end

endmodule
`default_nettype wire

/* sim/uemr_chk.sv */
// Port-level assertions for the endpoint mode responder
`timescale 1ns/1ps
`default_nettype none
`include "uemr_regs.vh"
module uemr_chk (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic TOKEN_VALID,
    input wire logic [1:0] TOKEN_TYPE,
    input wire logic TOKEN_OK,
    input wire logic RESP_VALID,
    input wire logic [2:0] RESP_CODE,
    input wire logic [3:0] RESP_LENGTH
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    wire take = TOKEN_VALID && TOKEN_OK;
    property p_cause; !take |=> !RESP_VALID; endproperty
    a_cause: assert property (p_cause) else $error("answer without token");
    property p_setup; take && TOKEN_TYPE == `UEMR_TOK_SETUP |=> !RESP_VALID || RESP_CODE == `UEMR_R_ACK; endproperty
    a_setup: assert property (p_setup) else $error("bad setup answer");
    property p_in; take && TOKEN_TYPE == `UEMR_TOK_IN |=> !RESP_VALID || RESP_CODE inside {[2:5]}; endproperty
    a_in: assert property (p_in) else $error("bad in answer");
    property p_out; take && TOKEN_TYPE == `UEMR_TOK_OUT |=> !RESP_VALID || RESP_CODE inside {[1:3]}; endproperty
    a_out: assert property (p_out) else $error("bad out answer");
    property p_len; RESP_VALID && RESP_CODE != `UEMR_R_TXCNT |-> RESP_LENGTH == 4'h0; endproperty
    a_len: assert property (p_len) else $error("length on empty answer");
    property p_once; RESP_VALID |=> !RESP_VALID; endproperty
    a_once: assert property (p_once) else $error("answer repeated");
    property p_apb; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
    a_apb: assert property (p_apb) else $error("bus answer late");
    property p_rst; $fell(RESET) |-> !RESP_VALID && !PREADY; endproperty
    a_rst: assert property (p_rst) else $error("busy out of reset");
    c_cnt: cover property (RESP_VALID && RESP_CODE == `UEMR_R_TXCNT);
    c_zero: cover property (RESP_VALID && RESP_CODE == `UEMR_R_TX0);
    c_stall: cover property (RESP_VALID && RESP_CODE == `UEMR_R_STALL);
endmodule
bind uemr_responder uemr_chk u_uemr_chk (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .TOKEN_VALID(TOKEN_VALID), .TOKEN_TYPE(TOKEN_TYPE), .TOKEN_OK(TOKEN_OK),
    .RESP_VALID(RESP_VALID), .RESP_CODE(RESP_CODE), .RESP_LENGTH(RESP_LENGTH));
`default_nettype wire

/* sim/uemr_host.sv */
// Host-side token source and answer capture
`timescale 1ns/1ps
`default_nettype none
module uemr_host (
    input wire logic clk,
    input wire logic rv,
    input wire logic [2:0] rc,
    input wire logic [3:0] rl,
    output var logic tv,
    output var logic [1:0] tt,
    output var logic tok,
    output var logic [3:0] ln,
    output var logic tg,
    output var logic ha
);
    logic [7:0] got;
    initial {tv, tt, tok, ln, tg, ha, got} = '0;
    // An answer stands one cycle, so catch it on every edge
    always @(posedge clk) if (rv) got <= {1'b1, rc, rl};
    // Released lines show the inverse so no stale value passes for data
    task automatic send(input logic [1:0] t, input logic ok, input logic [3:0] l, input logic g);
        @(posedge clk);
        got = '0;
        {tv, tt, tok, ln, tg} <= {1'b1, t, ok, l, g};
        @(posedge clk);
        {tv, tt, tok, ln, tg} <= {1'b0, ~t, ~ok, ~l, ~g};
        repeat (3) @(posedge clk);
    endtask
    task automatic ack;
        @(posedge clk);
        ha <= 1'b1;
        @(posedge clk);
        ha <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/usb_endpoint_mode_responder_tb.sv */
// Self-checking bench for the endpoint mode responder
`timescale 1ns/1ps
`default_nettype none
`include "uemr_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module usb_endpoint_mode_responder_tb;
    localparam logic [3:0] cnt = 4'h9;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, tv, tok_ok, tg, ha, rv;
    wire [1:0] tt;
    wire [3:0] ln, rl;
    wire [2:0] rc;
    int failures = 0, compares = 0;
    // Expected SETUP, IN, OUT answers per mode
    logic [8:0] tbl [16] = '{9'h000, 9'h052, 9'h059, 9'h05B, 9'h040, 9'h000, 9'h06B, 9'h000,
        9'h002, 9'h001, 9'h06A, 9'h051, 9'h010, 9'h020, 9'h051, 9'h061};
    always #10 clk = ~clk;
    uemr_responder u_uemr_responder (.CLOCK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TOKEN_VALID(tv), .TOKEN_TYPE(tt), .TOKEN_OK(tok_ok), .OUT_LENGTH(ln), .OUT_TOGGLE(tg),
        .HOST_ACK(ha), .RESP_VALID(rv), .RESP_CODE(rc), .RESP_LENGTH(rl));
    uemr_host u_uemr_host (.clk(clk), .rv(rv), .rc(rc), .rl(rl), .tv(tv), .tt(tt), .tok(tok_ok),
        .ln(ln), .tg(tg), .ha(ha));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("mismatch t=%0t bus answer timed out", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic setm(input logic [7:0] v);
        apb(1'b1, `UEMR_ADDR_MODE, {24'h0, v});
    endtask
    // Data answers are closed by the host so the next token is heard
    task automatic tok(input logic [1:0] t, input logic [3:0] l, input logic g, input logic [2:0] c);
        u_uemr_host.send(t, 1'b1, l, g);
        `CHK(u_uemr_host.got, {c != 3'h0, c, c == `UEMR_R_TXCNT ? cnt : 4'h0})
        if (c == `UEMR_R_TXCNT || c == `UEMR_R_TX0) u_uemr_host.ack();
    endtask
    task automatic t_reset;
        apb(1'b0, `UEMR_ADDR_MODE, 32'h0);
        `CHK(rd[3:0], 4'h0)
        tok(`UEMR_TOK_SETUP, 4'h0, 1'b1, `UEMR_R_NONE);
        apb(1'b0, `UEMR_ADDR_MODE, 32'h0);
        `CHK(rd[3:0], 4'h0)
        apb(1'b1, `UEMR_ADDR_COUNT, {28'h0, cnt});
    endtask
    task automatic t_table;
        for (int m = 0; m < 16; m++) for (int k = 1; k < 4; k++) if (m != 5 && m != 7) begin
            setm({4'h0, 4'(m)});
            tok(2'(k), 4'h0, 1'b1, tbl[m][3 * (3 - k) +: 3]);
        end
    endtask
    task automatic t_rewrite;
        logic [11:0] rw [5] = '{12'h311, 12'hB31, 12'h938, 12'hD2C, 12'hF2E};
        foreach (rw[i]) begin
            setm({4'h0, rw[i][11:8]});
            tok(rw[i][5:4], 4'h0, 1'b1, rw[i][5:4] == `UEMR_TOK_IN ? `UEMR_R_TXCNT : `UEMR_R_ACK);
            apb(1'b0, `UEMR_ADDR_MODE, 32'h0);
            `CHK(rd[3:0], rw[i][3:0])
        end
    endtask
    task automatic t_edge;
        setm(8'h89);
        tok(`UEMR_TOK_OUT, 4'h0, 1'b1, `UEMR_R_STALL);
        setm(8'h8D);
        tok(`UEMR_TOK_IN, 4'h0, 1'b1, `UEMR_R_STALL);
        setm(8'h0E);
        tok(`UEMR_TOK_OUT, 4'h1, 1'b1, `UEMR_R_STALL);
        setm(8'h0E);
        tok(`UEMR_TOK_OUT, 4'h0, 1'b0, `UEMR_R_STALL);
        u_uemr_host.send(`UEMR_TOK_OUT, 1'b0, 4'h0, 1'b1);
        `CHK(u_uemr_host.got, 8'h00)
    endtask
    task automatic t_status;
        apb(1'b0, `UEMR_ADDR_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h7)
        apb(1'b1, `UEMR_ADDR_STATUS, 32'h7);
        setm(8'h01);
        tok(`UEMR_TOK_SETUP, 4'h0, 1'b1, `UEMR_R_ACK);
        apb(1'b0, `UEMR_ADDR_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h1)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
    endtask
    task automatic report_and_stop;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_table();
        t_rewrite();
        t_edge();
        t_status();
        report_and_stop();
    end
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
